// ===== design/wdtps_top.sv
// Summary of operation
// - Watchdog counts on its own free-running RC oscillator, also during sleep.
// - Time-out while running normally requests a full device reset.
// - Time-out while asleep wakes the device instead of resetting.
// - Every time-out clears the active-low time-out flag.
// - With the configuration enable set, software cannot stop the watchdog.
// - With the configuration enable clear, the software enable alone runs it.
// - Three-bit field selects postscale 1:128 down to 1:1.
// - Kick, or sleep with no wake pending, zeroes counter and postscaler.
// - Kick with prescaler assigned clears its count, assignment kept.
// - Software enable resets to zero; zero stops only if config enable clear.
// - Sleep with no wake pending clears watchdog, keeps it running, clears power-down flag, sets time-out flag.
module wdtps_top #(
  parameter int BASE_COUNT = wdtps_pkg::BASE_COUNT_DFLT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [wdtps_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wdtps_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [wdtps_pkg::DATA_W-1:0] reg_rdata,
  // Core instruction strobes
  input wire logic kick_instruction,
  input wire logic sleep_instruction,
  input wire logic wake_request,
  input wire logic prescaler_assigned,
  // Watchdog oscillator and programmed configuration
  input wire logic rc_osc_clk,
  input wire logic [7:0] config_fuse,
  // Results
  output logic wdt_reset_req,
  output logic wdt_wake,
  output logic presc_clear,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic wdt_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  wdtps_pkg::wdtps_state_t state_ff;
  wdtps_pkg::wdtps_state_t nxt_state;
  logic osc_prev_ff;
  logic nxt_osc_prev;
  logic osc_tick;
  logic [7:0] cfg_ff;
  logic [7:0] nxt_cfg;
  logic cfg_loaded_ff;
  logic nxt_cfg_loaded;
  logic soft_on_ff;
  logic nxt_soft_on;
  logic to_n_ff;
  logic nxt_to_n;
  logic pwrdn_n_ff;
  logic nxt_pwrdn_n;
  logic [wdtps_pkg::STAT_W-1:0] stat_ff;
  logic [wdtps_pkg::STAT_W-1:0] nxt_stat;
  logic [wdtps_pkg::STAT_W-1:0] ien_ff;
  logic [wdtps_pkg::STAT_W-1:0] nxt_ien;
  logic [wdtps_pkg::STAT_W-1:0] stat_set;
  logic [wdtps_pkg::STAT_W-1:0] stat_clr;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic reset_req_ff;
  logic nxt_reset_req;
  logic wake_ff;
  logic nxt_wake;
  logic presc_clear_ff;
  logic nxt_presc_clear;
  logic cfg_on;
  logic wdt_run;
  logic sleep_exec;
  logic cnt_clear;
  logic cnt_timeout;
  logic to_evt;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator tick and run control
  // The RC clock is sampled; the core clock must outrun it by at least 2x
  assign nxt_osc_prev = rc_osc_clk;
  assign osc_tick = rc_osc_clk & ~osc_prev_ff;

  // Until the fuse byte is captured the configuration enable counts as off
  assign cfg_on = cfg_loaded_ff & cfg_ff[wdtps_pkg::CFG_ON_BIT];
  assign wdt_run = cfg_on | soft_on_ff;

  // A sleep with a wake source already pending completes as a no-op
  assign sleep_exec = sleep_instruction & ~wake_request;
  assign cnt_clear = kick_instruction | sleep_exec;
  // A kick in the same cycle as a time-out wins and prevents it
  assign to_evt = cnt_timeout & ~cnt_clear;

  wdtps_counter #(
    .BASE_COUNT(BASE_COUNT)
  ) u_counter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(wdt_run),
    .clear(cnt_clear),
    .osc_tick(osc_tick),
    .ratio_sel(cfg_ff[wdtps_pkg::PS_LSB +: wdtps_pkg::PS_W]),
    .timeout(cnt_timeout)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Power state and time-out actions
  always_comb begin
    nxt_state = state_ff;
    nxt_reset_req = 1'b0;
    nxt_wake = 1'b0;
    case (state_ff)
      wdtps_pkg::WDTPS_RUN: begin
        if (to_evt) begin
          nxt_reset_req = 1'b1;
        end else if (sleep_exec) begin
          nxt_state = wdtps_pkg::WDTPS_SLEEP;
        end
      end
      wdtps_pkg::WDTPS_SLEEP: begin
        if (to_evt) begin
          nxt_wake = 1'b1;
          nxt_state = wdtps_pkg::WDTPS_RUN;
        end else if (wake_request) begin
          nxt_state = wdtps_pkg::WDTPS_RUN;
        end
      end
      default: begin
        nxt_state = wdtps_pkg::WDTPS_RUN;
      end
    endcase
  end

  always_comb begin
    nxt_to_n = to_n_ff;
    nxt_pwrdn_n = pwrdn_n_ff;
    if (to_evt) begin
      nxt_to_n = 1'b0;
    end else if (sleep_exec) begin
      nxt_to_n = 1'b1;
    end
    if (sleep_exec) begin
      nxt_pwrdn_n = 1'b0;
    end
  end

  assign nxt_presc_clear = kick_instruction & prescaler_assigned;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= wdtps_pkg::WDTPS_RUN;
      reset_req_ff <= 1'b0;
      wake_ff <= 1'b0;
      to_n_ff <= wdtps_pkg::FLAG_RST;
      pwrdn_n_ff <= wdtps_pkg::FLAG_RST;
      presc_clear_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      reset_req_ff <= nxt_reset_req;
      wake_ff <= nxt_wake;
      to_n_ff <= nxt_to_n;
      pwrdn_n_ff <= nxt_pwrdn_n;
      presc_clear_ff <= nxt_presc_clear;
      osc_prev_ff <= nxt_osc_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_cfg_loaded = 1'b1;
    nxt_soft_on = soft_on_ff;
    nxt_ien = ien_ff;
    stat_clr = '0;
    // Fuse byte is caught once, after reset release, like a strap
    if (!cfg_loaded_ff) begin
      nxt_cfg = config_fuse & wdtps_pkg::CFG_RST;
    end
    if (reg_wr) begin
      case (reg_addr)
        wdtps_pkg::SOFT_ADDR: nxt_soft_on = reg_wdata[wdtps_pkg::SOFT_ON_BIT];
        wdtps_pkg::CLR_ADDR: stat_clr = reg_wdata[wdtps_pkg::STAT_W-1:0];
        wdtps_pkg::IEN_ADDR: nxt_ien = reg_wdata[wdtps_pkg::STAT_W-1:0];
        default: nxt_soft_on = soft_on_ff;
      endcase
    end
    stat_set = '0;
    stat_set[wdtps_pkg::STAT_RST_BIT] = nxt_reset_req;
    stat_set[wdtps_pkg::STAT_WAKE_BIT] = nxt_wake;
    // Set wins over a clear in the same cycle
    nxt_stat = (stat_ff & ~stat_clr) | stat_set;
  end

  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        wdtps_pkg::CFG_ADDR: nxt_rdata = cfg_ff;
        wdtps_pkg::SOFT_ADDR: nxt_rdata[wdtps_pkg::SOFT_ON_BIT] = soft_on_ff;
        wdtps_pkg::CAUSE_ADDR: begin
          nxt_rdata[wdtps_pkg::CAUSE_TO_BIT] = to_n_ff;
          nxt_rdata[wdtps_pkg::CAUSE_PWRDN_BIT] = pwrdn_n_ff;
        end
        wdtps_pkg::STAT_ADDR: nxt_rdata[wdtps_pkg::STAT_W-1:0] = stat_ff;
        wdtps_pkg::IEN_ADDR: nxt_rdata[wdtps_pkg::STAT_W-1:0] = ien_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_ff <= wdtps_pkg::CFG_RST;
      cfg_loaded_ff <= 1'b0;
      soft_on_ff <= wdtps_pkg::SOFT_RST;
      stat_ff <= wdtps_pkg::STAT_RST;
      ien_ff <= wdtps_pkg::IEN_RST;
      rdata_ff <= '0;
    end else if (ce) begin
      cfg_ff <= nxt_cfg;
      cfg_loaded_ff <= nxt_cfg_loaded;
      soft_on_ff <= nxt_soft_on;
      stat_ff <= nxt_stat;
      ien_ff <= nxt_ien;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = rdata_ff;
  assign wdt_reset_req = reset_req_ff;
  assign wdt_wake = wake_ff;
  assign presc_clear = presc_clear_ff;
  assign timeout_flag_n = to_n_ff;
  assign powerdown_flag_n = pwrdn_n_ff;
  assign wdt_irq = |(stat_ff & ien_ff);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_to_clears_flag;
    @(posedge core_clk) disable iff (!rst_n)
    ce && to_evt |=> !timeout_flag_n;
  endproperty
  a_to_clears_flag: assert property (p_to_clears_flag) else $error("time-out flag not cleared");

  property p_run_reset;
    @(posedge core_clk) disable iff (!rst_n)
    ce && to_evt && state_ff == wdtps_pkg::WDTPS_RUN |=> wdt_reset_req && !wdt_wake;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("no reset on time-out");

  property p_sleep_wake;
    @(posedge core_clk) disable iff (!rst_n)
    ce && to_evt && state_ff == wdtps_pkg::WDTPS_SLEEP
      |=> wdt_wake && !wdt_reset_req && state_ff == wdtps_pkg::WDTPS_RUN;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("no wake on time-out");

  property p_cfg_locks;
    @(posedge core_clk) disable iff (!rst_n)
    cfg_on |-> wdt_run;
  endproperty
  a_cfg_locks: assert property (p_cfg_locks) else $error("watchdog stopped");

  property p_soft_alone;
    @(posedge core_clk) disable iff (!rst_n)
    !cfg_on |-> wdt_run == soft_on_ff;
  endproperty
  a_soft_alone: assert property (p_soft_alone) else $error("soft enable ignored");

  property p_sleep_flags;
    @(posedge core_clk) disable iff (!rst_n)
    ce && sleep_exec && !cnt_timeout && state_ff == wdtps_pkg::WDTPS_RUN
      |=> !powerdown_flag_n && timeout_flag_n && state_ff == wdtps_pkg::WDTPS_SLEEP;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep entry wrong");

  property p_soft_write;
    @(posedge core_clk) disable iff (!rst_n)
    ce && reg_wr && reg_addr == wdtps_pkg::SOFT_ADDR
      |=> soft_on_ff == $past(reg_wdata[wdtps_pkg::SOFT_ON_BIT]);
  endproperty
  a_soft_write: assert property (p_soft_write) else $error("soft enable write lost");

  property p_presc_clear;
    @(posedge core_clk) disable iff (!rst_n)
    ce && kick_instruction |=> presc_clear == $past(prescaler_assigned);
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler clear wrong");

endmodule // wdtps_top

// ===== design/wdtps_pkg.sv
package wdtps_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus geometry
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [21:0] CFG_ADDR = 22'h30_0003;
  localparam logic [21:0] SOFT_ADDR = 22'h00_0010;
  localparam logic [21:0] CAUSE_ADDR = 22'h00_0011;
  localparam logic [21:0] STAT_ADDR = 22'h00_0012;
  localparam logic [21:0] CLR_ADDR = 22'h00_0013;
  localparam logic [21:0] IEN_ADDR = 22'h00_0014;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG_ON_BIT = 0;
  localparam int PS_LSB = 1;
  localparam int PS_W = 3;
  localparam int SOFT_ON_BIT = 0;
  localparam int CAUSE_PWRDN_BIT = 2;
  localparam int CAUSE_TO_BIT = 3;
  localparam int STAT_RST_BIT = 0;
  localparam int STAT_WAKE_BIT = 1;
  localparam int STAT_W = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h0F;
  localparam logic SOFT_RST = 1'b0;
  localparam logic FLAG_RST = 1'b1;
  localparam logic [1:0] IEN_RST = 2'h0;
  localparam logic [1:0] STAT_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Counting
  localparam int BASE_COUNT_DFLT = 256;
  localparam int POST_W = 7;
  localparam logic [6:0] POST_MAX_LAST = 7'h7F;

  typedef enum logic [1:0] {
    WDTPS_RUN = 2'b01,
    WDTPS_SLEEP = 2'b10
  } wdtps_state_t;

endpackage

// ===== design/wdtps_counter.sv
module wdtps_counter #(
  parameter int BASE_COUNT = wdtps_pkg::BASE_COUNT_DFLT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic clear,
  input wire logic osc_tick,
  input wire logic [wdtps_pkg::PS_W-1:0] ratio_sel,
  // Result
  output logic timeout
);

  localparam int CW = (BASE_COUNT < 2) ? 1 : $clog2(BASE_COUNT);
  localparam logic [CW-1:0] BASE_LAST = CW'(BASE_COUNT - 1);

  if (BASE_COUNT < 2) begin : g_bad_base
    $error("BASE_COUNT must be at least 2");
  end

  logic [CW-1:0] base_ff;
  logic [CW-1:0] nxt_base;
  logic [wdtps_pkg::POST_W-1:0] post_ff;
  logic [wdtps_pkg::POST_W-1:0] nxt_post;
  logic [wdtps_pkg::POST_W-1:0] post_last;
  logic timeout_ff;
  logic nxt_timeout;

  // 000 selects 1:128, 111 selects 1:1
  assign post_last = wdtps_pkg::POST_MAX_LAST >> ratio_sel;

  always_comb begin
    nxt_base = base_ff;
    nxt_post = post_ff;
    nxt_timeout = 1'b0;
    if (clear || !run) begin
      nxt_base = '0;
      nxt_post = '0;
    end else if (osc_tick) begin
      if (base_ff == BASE_LAST) begin
        nxt_base = '0;
        // Compare with >= so a lowered ratio cannot skip the terminal
        if (post_ff >= post_last) begin
          nxt_post = '0;
          nxt_timeout = 1'b1;
        end else begin
          nxt_post = post_ff + 1'b1;
        end
      end else begin
        nxt_base = base_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      base_ff <= '0;
      post_ff <= '0;
      timeout_ff <= 1'b0;
    end else if (ce) begin
      base_ff <= nxt_base;
      post_ff <= nxt_post;
      timeout_ff <= nxt_timeout;
    end
  end

  assign timeout = timeout_ff;

  property p_clear_zero;
    @(posedge core_clk) disable iff (!rst_n)
    ce && clear |=> base_ff == '0 && post_ff == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear left count");

  property p_terminal;
    @(posedge core_clk) disable iff (!rst_n)
    ce && run && !clear && osc_tick && base_ff == BASE_LAST && post_ff == post_last
      |=> timeout && post_ff == '0;
  endproperty
  a_terminal: assert property (p_terminal) else $error("no timeout at terminal");

endmodule // wdtps_counter

// ===== dv/wdtps_core_model.sv
module wdtps_core_model #(
  parameter int RC_HALF_NS = 420
) (
  // Core clock
  input wire logic core_clk,
  // Instruction side
  output logic kick_instruction,
  output logic sleep_instruction,
  output logic wake_request,
  output logic prescaler_assigned,
  // Watchdog oscillator
  output logic rc_osc_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    kick_instruction = 1'b0;
    sleep_instruction = 1'b0;
    wake_request = 1'b0;
    prescaler_assigned = 1'b0;
    rc_osc_clk = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Own phase, well below core_clk/2 so every edge is seen
  // Half period a multiple of 20 ns: no edge meets a core rising edge, no sampling race
  always begin
    #(RC_HALF_NS) rc_osc_clk = ~rc_osc_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic kick();
    @(posedge core_clk);
    kick_instruction <= 1'b1;
    @(posedge core_clk);
    kick_instruction <= 1'b0;
  endtask

  task automatic sleep();
    @(posedge core_clk);
    sleep_instruction <= 1'b1;
    @(posedge core_clk);
    sleep_instruction <= 1'b0;
  endtask

  task automatic set_wake(input logic v);
    @(posedge core_clk);
    wake_request <= v;
  endtask

  task automatic set_assign(input logic v);
    @(posedge core_clk);
    prescaler_assigned <= v;
  endtask
endmodule // wdtps_core_model

// ===== dv/tb.sv
`define CHK(g, e) chk(32'(g), 32'(e));

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BASE = 3;
  localparam int RC_HALF = 420;

  logic core_clk, rst_n, reg_wr, reg_rd;
  logic [21:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, config_fuse;
  logic kick_instruction, sleep_instruction, wake_request, prescaler_assigned, rc_osc_clk;
  logic wdt_reset_req, wdt_wake, presc_clear, timeout_flag_n, powerdown_flag_n, wdt_irq;
  logic p1, p2, ce;
  int err_count, n_checks, n;

  wdtps_top #(.BASE_COUNT(BASE)) u_wdtps_top (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .kick_instruction(kick_instruction),
    .sleep_instruction(sleep_instruction), .wake_request(wake_request),
    .prescaler_assigned(prescaler_assigned), .rc_osc_clk(rc_osc_clk),
    .config_fuse(config_fuse), .wdt_reset_req(wdt_reset_req), .wdt_wake(wdt_wake),
    .presc_clear(presc_clear), .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n), .wdt_irq(wdt_irq)
  );

  wdtps_core_model #(.RC_HALF_NS(RC_HALF)) u_wdtps_core_model (
    .core_clk(core_clk), .kick_instruction(kick_instruction),
    .sleep_instruction(sleep_instruction), .wake_request(wake_request),
    .prescaler_assigned(prescaler_assigned), .rc_osc_clk(rc_osc_clk)
  );

  always begin
    #50 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [21:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // Code 1 is a reset request, 2 a wake; bound exhausted while one is due ends the run
  task automatic wait_ev(input int bound, input int exp_code, output int cnt);
    int code;
    code = 0;
    cnt = 0;
    while (code == 0 && cnt < bound) begin
      @(posedge core_clk);
      #1;
      cnt++;
      if (wdt_reset_req === 1'b1) code = 1;
      else if (wdt_wake === 1'b1) code = 2;
    end
    `CHK(code, exp_code)
    if (exp_code != 0 && code == 0) end_of_test();
  endtask

  // Window allows one partial oscillator period plus start-up slack
  function automatic logic in_win(input int cnt, input int ratio);
    int e;
    e = BASE * ratio * 2 * RC_HALF / 100;
    return cnt >= e - 13 && cnt <= e + 4;
  endfunction

  task automatic do_reset(input logic [7:0] f);
    @(posedge core_clk);
    rst_n <= 1'b0;
    config_fuse <= f;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic kick_presc(input logic exp);
    u_wdtps_core_model.kick();
    #1 p1 = presc_clear;
    @(posedge core_clk);
    #1 p2 = presc_clear;
    `CHK(p1 | p2, exp)
    `CHK(p1 & p2, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    ce = 1'b1;
    reg_rd = 1'b0;
    reg_addr = 22'h00_0000;
    reg_wdata = 8'h00;
    config_fuse = 8'hF6;
    err_count = 0;
    n_checks = 0;
    do_reset(8'hF6);
    rd_chk(wdtps_pkg::SOFT_ADDR, 8'h00);
    rd_chk(wdtps_pkg::CAUSE_ADDR, 8'h0C);
    `CHK({timeout_flag_n, powerdown_flag_n}, 2'b11)
    rd_chk(wdtps_pkg::CFG_ADDR, 8'h06);
    wr(wdtps_pkg::CFG_ADDR, 8'hFF);
    rd_chk(wdtps_pkg::CFG_ADDR, 8'h06);
    rd_chk(22'h00_0020, 8'h00);
    $display("test map done");
    wait_ev(1000, 0, n);
    wr(wdtps_pkg::IEN_ADDR, 8'h03);
    wr(wdtps_pkg::SOFT_ADDR, 8'h01);
    wait_ev(700, 1, n);
    `CHK(in_win(n, 16), 1'b1)
    rd_chk(wdtps_pkg::SOFT_ADDR, 8'h01);
    rd_chk(wdtps_pkg::CAUSE_ADDR, 8'h04);
    rd_chk(wdtps_pkg::STAT_ADDR, 8'h01);
    `CHK(wdt_irq, 1'b1)
    wr(wdtps_pkg::CLR_ADDR, 8'h01);
    #1;
    `CHK(wdt_irq, 1'b0)
    rd_chk(wdtps_pkg::STAT_ADDR, 8'h00);
    $display("test soft enable done");
    u_wdtps_core_model.set_assign(1'b1);
    kick_presc(1'b1);
    for (int i = 0; i < 5; i++) begin
      wait_ev(150, 0, n);
      kick_presc(1'b1);
    end
    u_wdtps_core_model.set_assign(1'b0);
    kick_presc(1'b0);
    $display("test kick done");
    u_wdtps_core_model.sleep();
    rd_chk(wdtps_pkg::CAUSE_ADDR, 8'h08);
    `CHK({timeout_flag_n, powerdown_flag_n}, 2'b10)
    wait_ev(700, 2, n);
    rd_chk(wdtps_pkg::CAUSE_ADDR, 8'h00);
    `CHK({timeout_flag_n, powerdown_flag_n}, 2'b00)
    rd_chk(wdtps_pkg::STAT_ADDR, 8'h02);
    `CHK(wdt_irq, 1'b1)
    wr(wdtps_pkg::IEN_ADDR, 8'h01);
    #1;
    `CHK(wdt_irq, 1'b0)
    u_wdtps_core_model.set_wake(1'b1);
    u_wdtps_core_model.sleep();
    rd_chk(wdtps_pkg::CAUSE_ADDR, 8'h00);
    u_wdtps_core_model.set_wake(1'b0);
    wr(wdtps_pkg::SOFT_ADDR, 8'h00);
    wait_ev(1000, 0, n);
    $display("test sleep done");
    for (int s = 0; s < 8; s++) begin
      do_reset({4'h0, 3'(s), 1'b1});
      wr(wdtps_pkg::SOFT_ADDR, 8'h00);
      wait_ev(BASE * 256 * RC_HALF / 100 + 50, 1, n);
      `CHK(in_win(n, 128 >> s), 1'b1)
    end
    $display("test postscale done");
    // Enable low freezes the count; the time-out only follows once it returns
    do_reset(8'h0F);
    ce <= 1'b0;
    wait_ev(200, 0, n);
    ce <= 1'b1;
    wait_ev(60, 1, n);
    $display("test clock enable done");
    end_of_test();
  end
endmodule // tb
